// ---- core/dpsi_core.v ----
// operating-state machine and process-data receive set of the drive
`timescale 1ns/100ps
`include "dpsi_map.vh"

// How it works
// R1: any one condition triggers a transition
// R2: settle pulse on enable when toggle active
// R3: settle toggle at 5136, default one
// R4: fieldbus commands only in fieldbus mode
// R5: status word in bytes 9-10
// R6: mode status byte 11, inputs byte 12
// R7: 32-bit actual position in bytes 13-16
// R8: bytes 17-20 from selected parameter, unsynchronised
// R9: state low bits, fault, warn, halt
// R10: mode info, done, fault in bits 13-15
// R11: selected mode in mode status low bits
// R12: homed flag, kept with encoder fitted
// R13: rejected request sets request_rejected
// R14: echo handshake_toggle in bit 7
// R15: master waits for echoed toggle
// R16: input levels in input_signal_byte bits 0-5
// R17: mode activation only in Operation Enable
// R18: process data bits act on rising edge
// R19: parameter writes act on set bit
// R20: master holds enable while current wanted
// R21: disable 6-3-4, enable 4-5-6
// R22: quick stop moves 6 to 7
// R23: fault reset 9-3-4
// R24: mode data taken only on toggle change
// R25: class 2-4 error enters 8, then 9
// R26: unassigned status bits read zero
module dpsi_core #(
  parameter SETTLE_CYCLES = `DPSI_SETTLE_CYCLES,
  parameter ENCODER_FITTED = 1
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // control source and transition conditions
  input wire fieldbus_mode_i,
  input wire init_done_i,
  input wire power_ok_i,
  input wire power_fault_i,
  // error events
  input wire warn_i,
  input wire err_class1_i,
  input wire err_class2_4_i,
  input wire err_resp_done_i,
  input wire err_fatal_i,
  // operating mode status from the mode logic
  input wire mode_info_i,
  input wire mode_done_i,
  input wire mode_fault_i,
  input wire homing_ok_i,
  // process data from the master
  input wire pd_valid_i,
  input wire [15:0] pd_ctrl_word_i,
  input wire [7:0] pd_mode_ctrl_i,
  // parameter channel
  input wire par_wr_i,
  input wire [15:0] par_addr_i,
  input wire [15:0] par_wdata_i,
  output reg [15:0] par_rdata_o,
  // input pins
  input wire home_switch_input_i,
  input wire lower_travel_stop_i,
  input wire upper_travel_stop_i,
  input wire halt_input_i,
  input wire safety_cutoff_b_i,
  input wire safety_cutoff_a_i,
  // actual position and parameterised word
  input wire [31:0] actual_position_i,
  input wire [31:0] param_word_i,
  input wire param_strobe_i,
  // receive data set
  output reg [15:0] drive_status_word_o,
  output reg [7:0] mode_status_byte_o,
  output reg [7:0] input_signal_byte_o,
  output reg [31:0] actual_position_o,
  output reg [31:0] param_bytes_o,
  output wire [159:0] rx_frame_o,
  // to the mode logic and power stage
  output reg mode_start_o,
  output reg [6:0] mode_select_o,
  output wire power_stage_on_o,
  output wire quick_stop_o,
  output reg shaft_settle_o
);
  reg [3:0] state;
  reg [3:0] next_state;
  reg [15:0] shaft_settle_enable;
  reg fault_flag;
  reg warn_flag;
  reg homed_valid;
  reg request_rejected;
  reg handshake_toggle;
  reg [6:0] cur_mode;
  reg [15:0] settle_cnt;
  wire [3:0] pd_rise;
  wire [3:0] cmd;
  wire pd_act;
  wire par_ctrl_wr;
  wire mode_req;
  wire enter_on;

  function [7:0] byte_of;
    input [159:0] frame;
    input integer idx;
    begin
      byte_of = frame[idx*8 +: 8];
    end
  endfunction

  dpsi_edge #(
    .WIDTH(4)
  ) u_edge (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .level_i(pd_valid_i ? pd_ctrl_word_i[3:0] : 4'h0),
    .rise_o(pd_rise)
  );

  assign pd_act = fieldbus_mode_i; // R4
  assign par_ctrl_wr = par_wr_i && (par_addr_i == `DPSI_CTRL_ADDR);
  // edge on process data, level of set bits on parameter writes
  assign cmd = (pd_act ? pd_rise : 4'h0) | // R18
    ((pd_act && par_ctrl_wr) ? par_wdata_i[3:0] : 4'h0); // R19
  assign mode_req = pd_act && pd_valid_i &&
    (pd_mode_ctrl_i[7] != handshake_toggle); // R24

  // state machine; each transition fires on any one of its conditions
  always @* begin
    next_state = state;
    if (err_class2_4_i && state != `DPSI_ST_FAULT_RX && state != `DPSI_ST_FAULT) begin
      next_state = `DPSI_ST_FAULT_RX; // R25
    end else begin
      case (state)
        `DPSI_ST_NOT_READY: begin
          if (init_done_i)
            next_state = `DPSI_ST_SW_ON_DIS;
        end
        `DPSI_ST_SW_ON_DIS: begin
          if (power_ok_i)
            next_state = `DPSI_ST_READY; // R21
        end
        `DPSI_ST_READY: begin
          if (power_fault_i) // R1
            next_state = `DPSI_ST_SW_ON_DIS;
          else if (cmd[`DPSI_CW_ENABLE])
            next_state = `DPSI_ST_SWITCHED; // R21
        end
        `DPSI_ST_SWITCHED: begin
          if (cmd[`DPSI_CW_DISABLE])
            next_state = `DPSI_ST_SW_ON_DIS;
          else
            next_state = `DPSI_ST_OP_EN; // R21
        end
        `DPSI_ST_OP_EN: begin
          if (cmd[`DPSI_CW_DISABLE])
            next_state = `DPSI_ST_SW_ON_DIS; // R21
          else if (cmd[`DPSI_CW_QSTOP] || err_class1_i) // R1
            next_state = `DPSI_ST_QSTOP; // R22
        end
        `DPSI_ST_QSTOP: begin
          if (cmd[`DPSI_CW_DISABLE])
            next_state = `DPSI_ST_SW_ON_DIS;
          else if (cmd[`DPSI_CW_FRESET])
            next_state = `DPSI_ST_OP_EN;
        end
        `DPSI_ST_FAULT_RX: begin
          if (err_resp_done_i || err_fatal_i) // R1
            next_state = `DPSI_ST_FAULT; // R25
        end
        `DPSI_ST_FAULT: begin
          if (cmd[`DPSI_CW_FRESET])
            next_state = `DPSI_ST_SW_ON_DIS; // R23
        end
        default: next_state = `DPSI_ST_NOT_READY;
      endcase
    end
  end

  assign enter_on = (state == `DPSI_ST_SWITCHED) && (next_state == `DPSI_ST_OP_EN);
  assign power_stage_on_o = (state == `DPSI_ST_OP_EN) || (state == `DPSI_ST_QSTOP);
  assign quick_stop_o = (state == `DPSI_ST_QSTOP);

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      state <= `DPSI_ST_NOT_READY;
      shaft_settle_enable <= `DPSI_SETTLE_RESET; // R3
      fault_flag <= 1'b0;
      warn_flag <= 1'b0;
      homed_valid <= 1'b0;
      request_rejected <= 1'b0;
      handshake_toggle <= 1'b0;
      cur_mode <= 7'h00;
      mode_start_o <= 1'b0;
      mode_select_o <= 7'h00;
      settle_cnt <= 16'h0000;
      shaft_settle_o <= 1'b0;
    end else begin
      state <= next_state;
      if (par_wr_i && par_addr_i == `DPSI_SETTLE_ADDR)
        shaft_settle_enable <= par_wdata_i; // R3
      // settling motion on switching on; a set event wins over clearing
      if (enter_on && shaft_settle_enable[0]) begin
        settle_cnt <= SETTLE_CYCLES[15:0]; // R2
        shaft_settle_o <= 1'b1;
      end else if (settle_cnt != 16'h0000) begin
        settle_cnt <= settle_cnt - 16'h0001;
        shaft_settle_o <= (settle_cnt != 16'h0001);
      end
      if (err_class2_4_i)
        fault_flag <= 1'b1; // R9
      else if (state == `DPSI_ST_FAULT && cmd[`DPSI_CW_FRESET])
        fault_flag <= 1'b0;
      if (warn_i)
        warn_flag <= 1'b1;
      else if (cmd[`DPSI_CW_FRESET])
        warn_flag <= 1'b0;
      // homing result survives power stage disable only with an encoder
      if (homing_ok_i)
        homed_valid <= 1'b1; // R12
      else if (ENCODER_FITTED == 0 && !power_stage_on_o)
        homed_valid <= 1'b0;
      mode_start_o <= 1'b0;
      if (mode_req) begin
        handshake_toggle <= pd_mode_ctrl_i[7]; // R14
        if (state == `DPSI_ST_OP_EN) begin // R17
          cur_mode <= pd_mode_ctrl_i[6:0];
          mode_select_o <= pd_mode_ctrl_i[6:0];
          mode_start_o <= 1'b1;
          request_rejected <= 1'b0;
        end else begin
          request_rejected <= 1'b1; // R13
        end
      end
    end
  end

  // status word and mode status, refreshed each cycle
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      drive_status_word_o <= 16'h0000;
      mode_status_byte_o <= 8'h00;
      input_signal_byte_o <= 8'h00;
      actual_position_o <= 32'h00000000;
    end else begin
      drive_status_word_o <= {mode_fault_i, mode_done_i, mode_info_i, 4'h0, // R10
        halt_input_i, warn_flag, fault_flag, 2'b00, state}; // R9 R26
      mode_status_byte_o <= {handshake_toggle, request_rejected, homed_valid, // R14
        1'b0, cur_mode[3:0]}; // R11 R26
      input_signal_byte_o <= {2'b00, safety_cutoff_a_i, safety_cutoff_b_i, // R16
        halt_input_i, upper_travel_stop_i, lower_travel_stop_i, home_switch_input_i};
      actual_position_o <= actual_position_i; // R7
    end
  end

  // parameterised bytes follow their own strobe, not the status sampling
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      param_bytes_o <= 32'h00000000;
    end else if (param_strobe_i) begin
      param_bytes_o <= param_word_i; // R8
    end
  end

  // frame bytes 1-8 belong to the transport and stay zero here
  assign rx_frame_o = {param_bytes_o, actual_position_o, input_signal_byte_o,
    mode_status_byte_o, drive_status_word_o, 64'h0}; // R5 R6

  always @* begin
    if (par_addr_i == `DPSI_SETTLE_ADDR)
      par_rdata_o = shaft_settle_enable;
    else if (par_addr_i == `DPSI_CTRL_ADDR)
      par_rdata_o = {byte_of(rx_frame_o, `DPSI_RX_STAT_LO),
        byte_of(rx_frame_o, `DPSI_RX_STAT_LO - 1)};
    else
      par_rdata_o = 16'h0000;
  end
endmodule

// ---- core/dpsi_map.vh ----
// register offsets, field positions, reset values and timing counts of the process-data interface
`ifndef DPSI_MAP_VH
`define DPSI_MAP_VH

// parameter channel address of the settling-motion switch
`define DPSI_SETTLE_ADDR 16'h1410
`define DPSI_SETTLE_RESET 16'h0001
// parameter channel address of the control word (own choice)
`define DPSI_CTRL_ADDR 16'h1000

// receive data set byte positions
`define DPSI_RX_STAT_LO 9
`define DPSI_RX_MODE 11
`define DPSI_RX_IO 12
`define DPSI_RX_POS_LO 13
`define DPSI_RX_PAR_LO 17

// control word bits
`define DPSI_CW_DISABLE 0
`define DPSI_CW_ENABLE 1
`define DPSI_CW_QSTOP 2
`define DPSI_CW_FRESET 3

// status word bits
`define DPSI_SW_FAULT 6
`define DPSI_SW_WARN 7
`define DPSI_SW_HALT 8
`define DPSI_SW_MINFO 13
`define DPSI_SW_MDONE 14
`define DPSI_SW_MFAULT 15

// mode status bits
`define DPSI_MS_HOMED 5
`define DPSI_MS_REJECT 6
`define DPSI_MS_TOGGLE 7

// operating states
`define DPSI_ST_NOT_READY 4'h1
`define DPSI_ST_SW_ON_DIS 4'h3
`define DPSI_ST_READY 4'h4
`define DPSI_ST_SWITCHED 4'h5
`define DPSI_ST_OP_EN 4'h6
`define DPSI_ST_QSTOP 4'h7
`define DPSI_ST_FAULT_RX 4'h8
`define DPSI_ST_FAULT 4'h9

// length of the shaft settling pulse in clock cycles
`define DPSI_SETTLE_CYCLES 16

`endif

// ---- core/dpsi_edge.v ----
// rising-edge detector for a group of control bits
`timescale 1ns/100ps
module dpsi_edge #(
  parameter WIDTH = 4
) (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // level bits in, one-cycle edge pulses out
  input wire [WIDTH-1:0] level_i,
  output wire [WIDTH-1:0] rise_o
);
  reg [WIDTH-1:0] prev;
  genvar g;

  always @(posedge core_clk_i) begin
    if (rst_i) begin
      prev <= {WIDTH{1'b0}};
    end else begin
      prev <= level_i;
    end
  end

  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_rise
      assign rise_o[g] = level_i[g] & ~prev[g];
    end
  endgenerate
endmodule

// ---- tb/dpsi_master.sv ----
// fieldbus master model that drives the process data
`timescale 1ns/100ps
module dpsi_master (
  // clock
  input wire core_clk_i,
  // echoed mode status from the drive
  input wire [7:0] mode_status_i,
  // process data to the drive
  output reg pd_valid_o,
  output reg [15:0] pd_ctrl_o,
  output reg [7:0] pd_mode_o
);
  initial begin
    pd_valid_o = 1'b1;
    pd_ctrl_o = 16'h0000;
    pd_mode_o = 8'h00;
  end
  // a command is a new level; the enable bit stays up while current is wanted
  task ctrl(input [15:0] w);
    @(negedge core_clk_i);
    pd_ctrl_o = w;
  endtask
  // mode data is a separate request from state changes; bytes 17-20 are never
  // compared against bytes 9-16 in the same breath
  task mode(input flip, input [6:0] sel);
    integer n;
    @(negedge core_clk_i);
    pd_mode_o = {pd_mode_o[7] ^ flip, sel};
    n = 0;
    while (mode_status_i[7] !== pd_mode_o[7] && n < 20) begin
      @(negedge core_clk_i);
      n = n + 1;
    end
  endtask
endmodule

// ---- tb/dpsi_core_checker.sv ----
// assertions on the receive data set and state machine of the core
`timescale 1ns/100ps
module dpsi_core_checker (
  // clock and reset
  input wire core_clk_i,
  input wire rst_i,
  // watched inputs
  input wire fieldbus_mode_i,
  input wire err_class2_4_i,
  input wire mode_info_i,
  input wire mode_done_i,
  input wire mode_fault_i,
  input wire pd_valid_i,
  input wire [15:0] pd_ctrl_word_i,
  input wire [7:0] pd_mode_ctrl_i,
  input wire home_switch_input_i,
  input wire lower_travel_stop_i,
  input wire upper_travel_stop_i,
  input wire halt_input_i,
  input wire safety_cutoff_b_i,
  input wire safety_cutoff_a_i,
  // watched outputs
  input wire [15:0] drive_status_word_o,
  input wire [7:0] mode_status_byte_o,
  input wire [7:0] input_signal_byte_o,
  input wire [31:0] actual_position_o,
  input wire [159:0] rx_frame_o,
  input wire mode_start_o,
  input wire [6:0] mode_select_o,
  input wire power_stage_on_o,
  input wire quick_stop_o,
  input wire shaft_settle_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire [3:0] st = drive_status_word_o[3:0];
  // toggle last taken by the drive; the echoed copy in the status lags it by a cycle
  reg seen_tgl;
  wire rq = pd_valid_i && fieldbus_mode_i && (pd_mode_ctrl_i[7] != seen_tgl);
  always @(posedge core_clk_i) begin
    if (rst_i) begin
      seen_tgl <= 1'b0;
    end else if (rq) begin
      seen_tgl <= pd_mode_ctrl_i[7];
    end
  end
  wire op = power_stage_on_o && !quick_stop_o;
  a_frame: assert property (p_frame) else $error("receive set layout wrong");
  property p_frame;
    rx_frame_o[127:64] == {actual_position_o, input_signal_byte_o,
      mode_status_byte_o, drive_status_word_o};
  endproperty
  a_zero: assert property (p_zero) else $error("unassigned bit set");
  property p_zero;
    input_signal_byte_o[7:6] == 2'b00 && drive_status_word_o[12:9] == 4'h0
      && drive_status_word_o[5:4] == 2'b00 && !mode_status_byte_o[4];
  endproperty
  a_pins: assert property (p_pins) else $error("input byte wrong");
  property p_pins;
    !$past(rst_i) |-> input_signal_byte_o[5:0] == $past({safety_cutoff_a_i,
      safety_cutoff_b_i, halt_input_i, upper_travel_stop_i, lower_travel_stop_i,
      home_switch_input_i});
  endproperty
  a_mbits: assert property (p_mbits) else $error("mode flags wrong");
  property p_mbits;
    !$past(rst_i) |-> drive_status_word_o[15:13] == $past({mode_fault_i,
      mode_done_i, mode_info_i});
  endproperty
  a_auto: assert property (p_auto) else $error("no step 5 to 6");
  property p_auto;
    st == 4'h5 && !$past(err_class2_4_i) |=> st == 4'h6;
  endproperty
  a_echo: assert property (p_echo) else $error("toggle not echoed");
  property p_echo;
    rq |-> ##2 mode_status_byte_o[7] == $past(pd_mode_ctrl_i[7], 2);
  endproperty
  a_fbm: assert property (p_fbm) else $error("start outside fieldbus mode");
  property p_fbm;
    !fieldbus_mode_i |=> !mode_start_o;
  endproperty
  a_rej: assert property (p_rej) else $error("request not rejected");
  property p_rej;
    rq && !op |=> !mode_start_o ##1 mode_status_byte_o[6];
  endproperty
  a_start: assert property (p_start) else $error("mode not started");
  property p_start;
    rq && op && !err_class2_4_i |=> mode_start_o
      && mode_select_o == $past(pd_mode_ctrl_i[6:0]);
  endproperty
  a_nostart: assert property (p_nostart) else $error("start without toggle");
  property p_nostart;
    !rq |=> !mode_start_o;
  endproperty
  a_qs: assert property (p_qs) else $error("no quick stop");
  property p_qs;
    $rose(pd_ctrl_word_i[2]) && pd_valid_i && fieldbus_mode_i && op
      && !err_class2_4_i |=> quick_stop_o;
  endproperty
  a_settle: assert property (p_settle) else $error("settle off enable");
  property p_settle;
    $rose(shaft_settle_o) |-> ##[0:1] power_stage_on_o;
  endproperty
endmodule
bind dpsi_core dpsi_core_checker chk_u (.core_clk_i, .rst_i, .fieldbus_mode_i,
  .err_class2_4_i, .mode_info_i, .mode_done_i, .mode_fault_i, .pd_valid_i,
  .pd_ctrl_word_i, .pd_mode_ctrl_i, .home_switch_input_i, .lower_travel_stop_i,
  .upper_travel_stop_i, .halt_input_i, .safety_cutoff_b_i, .safety_cutoff_a_i,
  .drive_status_word_o, .mode_status_byte_o, .input_signal_byte_o,
  .actual_position_o, .rx_frame_o, .mode_start_o, .mode_select_o,
  .power_stage_on_o, .quick_stop_o, .shaft_settle_o);

// ---- tb/drive_process_data_state_interface_tb_top.sv ----
// test sequence for the drive process-data interface
`timescale 1ns/100ps
module drive_process_data_state_interface_tb_top;
  localparam SC = 4;
  reg clk, rst, fb, ini, pok, pfl, wrn, e1, e24, erd, eft, mi, md, mf, hok, pw, ps;
  reg [15:0] pa, pwd;
  reg [31:0] pos, pword;
  reg [5:0] pins;
  wire pv, sso, mst, pso, qso;
  wire [15:0] pc, sw, prd;
  wire [7:0] pm, ms, io;
  wire [6:0] msel;
  wire [159:0] frm;
  wire [31:0] apo, pbo;
  integer num_errors, samples_checked, i, n, nst;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  dpsi_master m (.core_clk_i(clk), .mode_status_i(ms), .pd_valid_o(pv), .pd_ctrl_o(pc),
    .pd_mode_o(pm));
  dpsi_core #(.SETTLE_CYCLES(SC)) dut_u (.core_clk_i(clk), .rst_i(rst), .fieldbus_mode_i(fb),
    .init_done_i(ini), .power_ok_i(pok), .power_fault_i(pfl), .warn_i(wrn),
    .err_class1_i(e1), .err_class2_4_i(e24), .err_resp_done_i(erd), .err_fatal_i(eft),
    .mode_info_i(mi), .mode_done_i(md), .mode_fault_i(mf), .homing_ok_i(hok),
    .pd_valid_i(pv), .pd_ctrl_word_i(pc), .pd_mode_ctrl_i(pm), .par_wr_i(pw),
    .par_addr_i(pa), .par_wdata_i(pwd), .par_rdata_o(prd), .home_switch_input_i(pins[0]),
    .lower_travel_stop_i(pins[1]), .upper_travel_stop_i(pins[2]), .halt_input_i(pins[3]),
    .safety_cutoff_b_i(pins[4]), .safety_cutoff_a_i(pins[5]),
    .actual_position_i(pos), .param_word_i(pword), .param_strobe_i(ps),
    .drive_status_word_o(sw), .mode_status_byte_o(ms), .input_signal_byte_o(io),
    .actual_position_o(apo), .param_bytes_o(pbo), .rx_frame_o(frm), .mode_start_o(mst),
    .mode_select_o(msel), .power_stage_on_o(pso), .quick_stop_o(qso), .shaft_settle_o(sso));
  // counts mode start pulses; one per accepted request, none for a refused one
  always @(negedge clk) begin
    if (rst) begin
      nst <= 0;
    end else begin
      nst <= nst + mst;
    end
  end
  task cyc(input integer k);
    repeat (k) @(negedge clk);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task pwr(input [15:0] a, input [15:0] d);
    @(negedge clk);
    pa = a;
    pwd = d;
    pw = 1'b1;
    @(negedge clk);
    pw = 1'b0;
  endtask
  // counts settle cycles over a window long enough for the whole pulse
  task settle(input [15:0] exp);
    n = 0;
    repeat (30) begin
      @(negedge clk);
      n = n + sso;
    end
    chk(n, exp);
  endtask
  task tend(input integer k);
    $display("test %0d done", k);
  endtask
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #200000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    {fb, ini, pok, pfl, wrn, e1, e24, erd, eft, mi, md, mf, hok, pw, ps, pins} = 0;
    pos = 32'h12345678;
    pword = 32'h5a5a0001;
    pa = 16'h1410;
    pwd = 16'h0000;
    rst = 1'b1;
    num_errors = 0;
    samples_checked = 0;
    cyc(8);
    rst = 1'b0;
    cyc(2);
    chk(sw[3:0], 4'h1);
    chk(prd, 16'h0001);
    {ini, pok, fb} = 3'b111;
    cyc(6);
    chk(sw[3:0], 4'h4);
    {pok, pfl} = 2'b01;
    cyc(3);
    chk(sw[3:0], 4'h3);
    {pok, pfl} = 2'b10;
    cyc(3);
    chk(sw[3:0], 4'h4);
    chk({pso, qso}, 2'b00);
    m.mode(1'b1, 7'h01);
    cyc(1);
    chk(ms[7:6], 2'b11);
    chk(nst, 0);
    tend(1);
    fb = 1'b0;
    m.ctrl(16'h0002);
    cyc(4);
    chk(sw[3:0], 4'h4);
    m.ctrl(16'h0000);
    fb = 1'b1;
    m.ctrl(16'h0002);
    settle(SC);
    chk(sw[3:0], 4'h6);
    chk({pso, qso}, 2'b10);
    m.mode(1'b1, 7'h03);
    cyc(1);
    chk(msel, 7'h03);
    chk(ms[3:0], 4'h3);
    chk(nst, 1);
    m.mode(1'b0, 7'h05);
    cyc(2);
    chk(msel, 7'h03);
    chk(nst, 1);
    tend(2);
    {hok, wrn, mi, md, mf} = 5'h1f;
    cyc(1);
    hok = 1'b0;
    for (i = 0; i < 6; i = i + 1) begin
      pins = 6'h01 << i;
      cyc(2);
      chk(io, 8'h01 << i);
    end
    chk(sw[15:6], 10'h382);
    {wrn, mi, md, mf, pins} = 0;
    ps = 1'b1;
    cyc(1);
    ps = 1'b0;
    pos = 32'h0badf00d;
    pword = 32'h00c0ffee;
    cyc(2);
    chk(frm[159:128], 32'h5a5a0001);
    chk(pbo, 32'h5a5a0001);
    chk(frm[127:96], 32'h0badf00d);
    chk(apo, 32'h0badf00d);
    tend(3);
    m.ctrl(16'h0006);
    cyc(4);
    chk(sw[3:0], 4'h7);
    chk({pso, qso}, 2'b11);
    m.ctrl(16'h000e);
    cyc(4);
    chk(sw[3:0], 4'h6);
    m.ctrl(16'h000f);
    cyc(5);
    chk(sw[3:0], 4'h4);
    chk(ms[5], 1'b1);
    m.ctrl(16'h0000);
    tend(4);
    pwr(16'h1410, 16'h0000);
    chk(prd, 16'h0000);
    pwr(16'h1000, 16'h0002);
    settle(0);
    chk(sw[3:0], 4'h6);
    e1 = 1'b1;
    cyc(1);
    e1 = 1'b0;
    cyc(2);
    chk(sw[3:0], 4'h7);
    pwr(16'h1000, 16'h0008);
    cyc(2);
    chk(sw[3:0], 4'h6);
    pwr(16'h1000, 16'h0001);
    cyc(4);
    chk(sw[3:0], 4'h4);
    tend(5);
    e24 = 1'b1;
    cyc(3);
    chk(sw[3:0], 4'h8);
    chk(sw[6], 1'b1);
    e24 = 1'b0;
    erd = 1'b1;
    cyc(3);
    erd = 1'b0;
    chk(sw[3:0], 4'h9);
    m.ctrl(16'h0008);
    cyc(5);
    chk(sw[3:0], 4'h4);
    e24 = 1'b1;
    cyc(1);
    {e24, eft} = 2'b01;
    cyc(1);
    eft = 1'b0;
    cyc(2);
    chk(sw[3:0], 4'h9);
    m.ctrl(16'h0000);
    m.ctrl(16'h0008);
    cyc(5);
    chk(sw[3:0], 4'h4);
    chk({pso, qso}, 2'b00);
    tend(6);
    end_sim;
  end
endmodule
